// ---- design/lpd_pkg.sv ----
// shared constants of the pwm status-frame and diagnostic block
package lpd_pkg;
	// ********************************************************************
	// frame geometry
	// ********************************************************************
	localparam int CHANNELS = 32'h30;
	localparam int FRAME_BITS = 32'h248;
	localparam int CNT_W = 32'ha;
	localparam int FIELD_W = 32'hc;
	localparam int COR_W = 32'h6;
	localparam int COR_LSB = 32'h6;
	localparam int CMD_W = 32'h8;
	localparam int CMD_NIB_W = 32'h4;
	localparam int CH_IDX_W = 32'h6;
	localparam int RES_W = 32'h7;
	// ********************************************************************
	// commands, upper nibble of the frame's command byte
	// ********************************************************************
	localparam logic [3:0] CMD_COR = 4'h2;
	localparam logic [3:0] CMD_TEST = 4'h5;
	localparam logic [3:0] CMD_PHS = 4'h6;
	localparam logic [3:0] CMD_CRD = 4'h7;
	// ********************************************************************
	// reset values, timing, buffering
	// ********************************************************************
	localparam logic [5:0] COR_RST = 6'h00;
	localparam logic NOL_RST = 1'h1;
	localparam logic PHS_RST = 1'h0;
	localparam logic CRD_RST = 1'h0;
	localparam int TEST_PWM_CYCLES = 32'h40;
	localparam int RES_FIFO_DEPTH = 32'h4;
	// ********************************************************************
	// positions in the input synchroniser vector
	// ********************************************************************
	localparam int SY_SDI = 32'h0;
	localparam int SY_SCK = 32'h1;
	localparam int SY_LDI = 32'h2;
	localparam int SY_PCK = 32'h3;
	localparam int SY_OPN = 32'h4;
	localparam int SY_W = 32'h5;
endpackage // lpd_pkg

// ---- design/lpd_strm_if.sv ----
// valid/ready word stream between the block's own modules
interface lpd_strm_if #(
	parameter int W = 8
) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface // lpd_strm_if

// ---- design/lpd_fifo.sv ----
// small flip-flop fifo with valid/ready on both sides
module lpd_fifo
	import lpd_pkg::*;
#(
	parameter int W = RES_W,
	parameter int DEPTH = RES_FIFO_DEPTH
) (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// streams
	lpd_strm_if.snk wr,
	lpd_strm_if.src rd
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
	} lpd_fifo_st_t;
	lpd_fifo_st_t r, n;
	logic push, pop;
	assign wr.ready = (r.cnt != CW'(DEPTH));
	assign rd.valid = (r.cnt != '0);
	assign rd.data = r.mem[r.rp];
	assign push = wr.valid & wr.ready;
	assign pop = rd.valid & rd.ready;
	always_comb begin
		n = r;
		if (push) begin
			n.mem[r.wp] = wr.data;
			n.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : r.wp + PW'(1);
		end
		if (pop) begin
			n.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + PW'(1);
		end
		n.cnt = r.cnt + CW'(push) - CW'(pop);
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule // lpd_fifo

// ---- design/lpd_selftest.sv ----
// sequential per-channel open-string self test
module lpd_selftest
	import lpd_pkg::*;
#(
	parameter int CH = CHANNELS,
	parameter int HOLD = TEST_PWM_CYCLES
) (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic start_i,
	input wire logic pwm_rise_i,
	input wire logic open_i,
	output logic busy_o,
	output logic done_o,
	output logic [CH-1:0] pwm_o,
	// results
	lpd_strm_if.src res
);
	localparam int HW = $clog2(HOLD);
	typedef enum logic [1:0] {ST_IDLE, ST_DRIVE, ST_SEND} lpd_test_state_t;
	typedef struct packed {
		lpd_test_state_t state;
		logic [CH_IDX_W-1:0] ch;
		logic [HW-1:0] cnt;
		logic smp;
		logic done;
		logic [CH-1:0] oh;
		logic [CH-1:0] pwm;
	} lpd_test_st_t;
	lpd_test_st_t r, n;
	assign res.valid = (r.state == ST_SEND);
	assign res.data = {r.ch, r.smp};
	assign busy_o = (r.state != ST_IDLE);
	assign done_o = r.done;
	assign pwm_o = r.pwm;
	always_comb begin
		n = r;
		n.done = 1'b0;
		case (r.state)
			ST_IDLE: begin
				if (start_i) begin
					n.state = ST_DRIVE;
					n.ch = '0;
					n.cnt = '0;
					n.oh = CH'(1);
					n.pwm = CH'(1);
				end
			end
			ST_DRIVE: begin
				// only one output is high at a time
				if (pwm_rise_i) begin
					if (r.cnt == HW'(HOLD - 1)) begin
						n.smp = open_i;
						n.pwm = '0;
						n.state = ST_SEND;
					end else begin
						n.cnt = r.cnt + HW'(1);
					end
				end
			end
			ST_SEND: begin
				// a full result buffer holds the test here
				if (res.ready) begin
					if (r.ch == CH_IDX_W'(CH - 1)) begin
						n.state = ST_IDLE;
						n.done = 1'b1;
					end else begin
						n.ch = r.ch + CH_IDX_W'(1);
						n.cnt = '0;
						n.oh = {r.oh[CH-2:0], 1'b0};
						n.pwm = {r.oh[CH-2:0], 1'b0};
						n.state = ST_DRIVE;
					end
				end
			end
			default: begin
				n.state = ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
			r.state <= ST_IDLE;
		end else begin
			r <= n;
		end
	end
endmodule // lpd_selftest

// ---- design/lpd_status_top.sv ----
// top of the status-frame and diagnostic logic of the 48-channel pwm generator
// Behaviour
// - each device's frame is 584 serial clocks; host adds one cycle for the strobe
// - a status frame leaves on serial out while the next frame comes in
// - status changes only on a command, except the diagnostic flags
// - each status frame carries corrections, test, phase and correction-off bits
// - the five spare bits of every channel field read as zero
// - strobe before 584 clocks, or while serial clock is high, is a sync error
// - the sync flag reports only the error of the strobe that captures the frame
// - repeated strobes with no serial clock between are not an error
// - every strobe resets the serial interface: bit counter and alignment
// - open-string input is sampled on the first serial clock rise after a strobe
// - sampled low clears all 48 open flags; high sets all of them
// - self test drives each output alone for 64 pwm clocks and records input
// - test results replace the open flags and set the test indicator
// - one frame later the indicator clears and flags follow the sampled input
// - command 0x6 toggles phase-shift mode, clear after reset, always reported
// - command 0x7 toggles correction disable, clear after reset, always reported
module lpd_status_top
	import lpd_pkg::*;
(
	// system
	input wire logic MCLK_I,
	input wire logic RST_I,
	// serial link
	input wire logic SERIAL_DATA_IN_I,
	input wire logic SERIAL_CLOCK_IN_I,
	input wire logic LOAD_STROBE_I,
	output logic SERIAL_DATA_OUT_O,
	output logic SERIAL_CLOCK_OUT_O,
	// pwm side
	input wire logic PWM_CLOCK_I,
	input wire logic OPEN_STRING_INPUT_I,
	output logic [CHANNELS-1:0] PWM_O,
	// mode and diagnostic levels
	output logic PHASE_SHIFT_MODE_O,
	output logic CORRECTION_DISABLE_O,
	output logic OUT_OF_SYNC_FLAG_O,
	output logic OPEN_TEST_INDICATOR_O,
	output logic SELF_TEST_BUSY_O,
	output logic RESULT_FIFO_FULL_O
);
	// ********************************************************************
	// state
	// ********************************************************************
	typedef struct packed {
		logic [SY_W-1:0] sy1;
		logic [SY_W-1:0] sy2;
		logic [SY_W-1:0] sy3;
		logic [FRAME_BITS-1:0] sh;
		logic [CNT_W-1:0] cnt;
		logic serial_data_out;
		logic sco;
		logic [CHANNELS-1:0][COR_W-1:0] channel_correction_value;
		logic [CHANNELS-1:0] open_string_flags;
		logic out_of_sync_flag;
		logic open_test_indicator;
		logic phase_shift_mode;
		logic correction_disable;
		logic fin;
		logic go;
		logic busy;
		logic full;
	} lpd_top_st_t;
	lpd_top_st_t r, n;

	// ********************************************************************
	// events seen through the synchronisers
	// ********************************************************************
	logic sck_rise;
	logic sck_fall;
	logic sck_high;
	logic ldi_rise;
	logic pck_rise;
	logic frame_full;
	logic frame_empty;
	logic frame_ok;
	logic sync_err;
	logic [CMD_NIB_W-1:0] cmd_nib;

	// edges are taken between the second and third stage only
	assign sck_rise = r.sy2[SY_SCK] & ~r.sy3[SY_SCK];
	assign sck_fall = ~r.sy2[SY_SCK] & r.sy3[SY_SCK];
	assign sck_high = r.sy2[SY_SCK];
	assign ldi_rise = r.sy2[SY_LDI] & ~r.sy3[SY_LDI];
	assign pck_rise = r.sy2[SY_PCK] & ~r.sy3[SY_PCK];

	// the counter saturates, so a cascade of any length ends in a full frame
	assign frame_full = (r.cnt == CNT_W'(FRAME_BITS));
	assign frame_empty = (r.cnt == '0);

	// a strobe with no clock since the last one leaves the counter at zero
	assign sync_err = ldi_rise & ((~frame_full & ~frame_empty) | sck_high);
	assign frame_ok = ldi_rise & frame_full & ~sck_high;
	assign cmd_nib = r.sh[FRAME_BITS-1 -: CMD_NIB_W];

	// ********************************************************************
	// command decode
	// ********************************************************************
	logic phs_new;
	logic crd_new;
	logic cor_load;
	logic test_req;
	logic syc_cap;

	// a corrupted frame executes no command, modes are left as they were
	assign phs_new = r.phase_shift_mode ^ (frame_ok & (cmd_nib == CMD_PHS));
	assign crd_new = r.correction_disable ^ (frame_ok & (cmd_nib == CMD_CRD));
	assign cor_load = frame_ok & (cmd_nib == CMD_COR);
	assign test_req = frame_ok & (cmd_nib == CMD_TEST) & ~r.busy & ~r.fin;

	// errors arise only at a strobe, so each capture reports its own strobe alone
	assign syc_cap = sync_err;

	// ********************************************************************
	// status frame assembly
	// ********************************************************************
	logic [CHANNELS-1:0][COR_W-1:0] cor_new;
	logic [FRAME_BITS-1:0] stat_w;

	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
		assign cor_new[c] = cor_load ? r.sh[c*FIELD_W+COR_LSB +: COR_W] : r.channel_correction_value[c];
		// correction, five zero bits, open flag
		assign stat_w[c*FIELD_W +: FIELD_W] = {cor_new[c], {(FIELD_W-COR_W-1){1'b0}}, r.open_string_flags[c]};
	end

	// global byte: sync, test indicator, phase shift, correction off
	assign stat_w[FRAME_BITS-1 -: CMD_W] = {syc_cap, r.open_test_indicator, phs_new, crd_new, 4'h0};

	// ********************************************************************
	// self test and its result path
	// ********************************************************************
	lpd_strm_if #(.W(RES_W)) res_a ();
	lpd_strm_if #(.W(RES_W)) res_b ();

	logic st_busy;
	logic st_done;
	logic drain_ok;
	logic [CH_IDX_W-1:0] res_idx;
	logic res_bit;

	lpd_selftest #(
		.CH(CHANNELS),
		.HOLD(TEST_PWM_CYCLES)
	) u_test (
		.clk_i(MCLK_I),
		.rst_i(RST_I),
		.start_i(r.go),
		.pwm_rise_i(pck_rise),
		.open_i(r.sy2[SY_OPN]),
		.busy_o(st_busy),
		.done_o(st_done),
		.pwm_o(PWM_O),
		.res(res_a.src)
	);

	lpd_fifo #(
		.W(RES_W),
		.DEPTH(RES_FIFO_DEPTH)
	) u_fifo (
		.clk_i(MCLK_I),
		.rst_i(RST_I),
		.wr(res_a.snk),
		.rd(res_b.src)
	);

	// flags are frozen while the strobe is high so a snapshot never straddles
	// a result write; a long strobe therefore backs the test up
	assign drain_ok = ~r.sy2[SY_LDI];
	assign res_b.ready = drain_ok;
	assign res_idx = res_b.data[RES_W-1:1];
	assign res_bit = res_b.data[0];

	// ********************************************************************
	// next state
	// ********************************************************************
	always_comb begin
		n = r;
		n.go = 1'b0;
		n.busy = st_busy;
		n.full = ~res_a.ready;

		// two stages on every pin before any logic looks at it
		n.sy1 = {OPEN_STRING_INPUT_I, PWM_CLOCK_I, LOAD_STROBE_I, SERIAL_CLOCK_IN_I, SERIAL_DATA_IN_I};
		n.sy2 = r.sy1;
		n.sy3 = r.sy2;
		n.sco = r.sy2[SY_SCK];

		// incoming data shifts through the same register that holds status
		if (sck_rise) begin
			n.sh = {r.sh[FRAME_BITS-2:0], r.sy2[SY_SDI]};
			if (!frame_full) begin
				n.cnt = r.cnt + CNT_W'(1);
			end
			// pending test results keep the flags until they are reported
			if (frame_empty && !r.open_test_indicator && !r.busy && !r.fin) begin
				n.open_string_flags = {CHANNELS{r.sy2[SY_OPN]}};
			end
		end

		// out data changes on the falling edge, ready for the next rise
		if (sck_fall) begin
			n.serial_data_out = r.sh[FRAME_BITS-1];
		end

		// one result per accepted word overwrites its channel's flag
		if (res_b.valid && drain_ok) begin
			n.open_string_flags[res_idx] = res_bit;
		end

		if (st_done) begin
			n.fin = 1'b1;
		end

		// the indicator waits until the last buffered result is written
		if (r.fin && !res_b.valid) begin
			n.fin = 1'b0;
			n.open_test_indicator = 1'b1;
		end

		// strobe: execute, capture the status frame, restart the interface
		if (ldi_rise) begin
			n.cnt = '0;
			n.sh = stat_w;
			n.serial_data_out = stat_w[FRAME_BITS-1];
			n.phase_shift_mode = phs_new;
			n.correction_disable = crd_new;
			n.channel_correction_value = cor_new;
			n.go = test_req;
			// the port shows the bit just captured; the next capture starts afresh
			n.out_of_sync_flag = syc_cap;
			if (r.open_test_indicator) begin
				n.open_test_indicator = 1'b0;
			end
		end
	end

	// ********************************************************************
	// registers
	// ********************************************************************
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			r <= '0;
			r.channel_correction_value <= {CHANNELS{COR_RST}};
			r.open_string_flags <= {CHANNELS{NOL_RST}};
			r.phase_shift_mode <= PHS_RST;
			r.correction_disable <= CRD_RST;
		end else begin
			r <= n;
		end
	end

	// ********************************************************************
	// outputs
	// ********************************************************************
	assign SERIAL_DATA_OUT_O = r.serial_data_out;
	assign SERIAL_CLOCK_OUT_O = r.sco;
	assign PHASE_SHIFT_MODE_O = r.phase_shift_mode;
	assign CORRECTION_DISABLE_O = r.correction_disable;
	assign OUT_OF_SYNC_FLAG_O = r.out_of_sync_flag;
	assign OPEN_TEST_INDICATOR_O = r.open_test_indicator;
	assign SELF_TEST_BUSY_O = r.busy;
	assign RESULT_FIFO_FULL_O = r.full;
endmodule // lpd_status_top

// ---- test/lpd_led_model.sv ----
// led driver stand-in: wired open-string line and a free-running pwm clock
module lpd_led_model
	import lpd_pkg::*;
(
	// pwm side
	input wire logic [CHANNELS-1:0] pwm_i,
	input wire logic [CHANNELS-1:0] open_mask_i,
	input wire logic fault_i,
	// to the device
	output logic pwm_clk_o,
	output logic open_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pwm_clk_o = 1'h0;
	// the pwm clock runs free, unrelated to the serial clock
	always #80 pwm_clk_o = ~pwm_clk_o;
	// pulled up; an open string pulls low only while its output is driven
	assign open_o = !(fault_i || |(pwm_i & open_mask_i));
endmodule // lpd_led_model

// ---- test/lpd_status_checker.sv ----
// assertions on the ports of the pwm status top
module lpd_status_checker
	import lpd_pkg::*;
(
	// system
	input wire logic MCLK_I,
	input wire logic RST_I,
	// serial link
	input wire logic SERIAL_CLOCK_IN_I,
	input wire logic LOAD_STROBE_I,
	input wire logic SERIAL_DATA_OUT_O,
	input wire logic SERIAL_CLOCK_OUT_O,
	// pwm and status
	input wire logic [CHANNELS-1:0] PWM_O,
	input wire logic PHASE_SHIFT_MODE_O,
	input wire logic CORRECTION_DISABLE_O,
	input wire logic OUT_OF_SYNC_FLAG_O,
	input wire logic OPEN_TEST_INDICATOR_O,
	input wire logic SELF_TEST_BUSY_O
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// pin event ages
	// ****************
	logic ld_q_r, sk_q_r;
	logic [3:0] ld_age_r, fl_age_r;
	// inputs pass a synchroniser, so effects land a few clocks after the pin
	wire ld_new = ld_age_r <= 4'h8;
	wire fl_new = fl_age_r <= 4'h8;
	always_ff @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			ld_q_r <= 1'h0;
			sk_q_r <= 1'h0;
			ld_age_r <= 4'hf;
			fl_age_r <= 4'hf;
		end else begin
			ld_q_r <= LOAD_STROBE_I;
			sk_q_r <= SERIAL_CLOCK_IN_I;
			ld_age_r <= (LOAD_STROBE_I && !ld_q_r) ? 4'h0 : ld_age_r + {3'h0, ~&ld_age_r};
			fl_age_r <= (sk_q_r && !SERIAL_CLOCK_IN_I) ? 4'h0 : fl_age_r + {3'h0, ~&fl_age_r};
		end
	end
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (RST_I);
	sequence s_ch0;
		##[0:2] (PWM_O == 48'h1);
	endsequence
	sequence s_fwd;
		##[2:5] $rose(SERIAL_CLOCK_OUT_O);
	endsequence
	property p_one; $onehot0(PWM_O); endproperty
	a_one: assert property (p_one) else $error("two pwm outputs high");
	property p_pwb; (PWM_O != 48'h0) |=> SELF_TEST_BUSY_O; endproperty
	a_pwb: assert property (p_pwb) else $error("pwm driven while idle");
	property p_go; $rose(SELF_TEST_BUSY_O) |-> ld_new ##0 s_ch0; endproperty
	a_go: assert property (p_go) else $error("test start wrong");
	property p_phs; $changed(PHASE_SHIFT_MODE_O) |-> ld_new; endproperty
	a_phs: assert property (p_phs) else $error("phase moved off strobe");
	property p_crd; $changed(CORRECTION_DISABLE_O) |-> ld_new; endproperty
	a_crd: assert property (p_crd) else $error("disable moved off strobe");
	property p_syn; $changed(OUT_OF_SYNC_FLAG_O) |-> ld_new; endproperty
	a_syn: assert property (p_syn) else $error("sync flag moved off strobe");
	property p_sdo; $changed(SERIAL_DATA_OUT_O) |-> ld_new || fl_new; endproperty
	a_sdo: assert property (p_sdo) else $error("serial out moved off fall");
	property p_fwd; $rose(SERIAL_CLOCK_IN_I) |-> s_fwd; endproperty
	a_fwd: assert property (p_fwd) else $error("clock not forwarded");
	property p_olt; $fell(OPEN_TEST_INDICATOR_O) |-> ld_new; endproperty
	a_olt: assert property (p_olt) else $error("test bit cleared off strobe");
endmodule // lpd_status_checker

bind lpd_status_top lpd_status_checker u_chk (.*);

// ---- test/lpd_status_top_tb.sv ----
// self-checking bench for the pwm status-frame block
module lpd_status_top_tb
	import lpd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// stimulus and wiring
	// ****************
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic serial_data_in = 1'h0;
	logic sck = 1'h0;
	logic load_strobe = 1'h0;
	logic flt = 1'h0;
	logic fs = 1'h0;
	logic [CHANNELS-1:0] msk = 48'h0;
	logic serial_data_out, sko, pck, opn, phase_shift_mode, correction_disable, syn, open_test_indicator, bsy, ful;
	logic [CHANNELS-1:0] pwm;
	logic [FRAME_BITS-1:0] rx;
	int fail_count = 0;
	int compares = 0;
	always #10 clk = ~clk;
	lpd_status_top dut (.MCLK_I(clk), .RST_I(rst), .SERIAL_DATA_IN_I(serial_data_in), .SERIAL_CLOCK_IN_I(sck),
		.LOAD_STROBE_I(load_strobe), .SERIAL_DATA_OUT_O(serial_data_out), .SERIAL_CLOCK_OUT_O(sko), .PWM_CLOCK_I(pck),
		.OPEN_STRING_INPUT_I(opn), .PWM_O(pwm), .PHASE_SHIFT_MODE_O(phase_shift_mode), .CORRECTION_DISABLE_O(correction_disable),
		.OUT_OF_SYNC_FLAG_O(syn), .OPEN_TEST_INDICATOR_O(open_test_indicator), .SELF_TEST_BUSY_O(bsy),
		.RESULT_FIFO_FULL_O(ful));
	lpd_led_model led (.pwm_i(pwm), .open_mask_i(msk), .fault_i(flt), .pwm_clk_o(pck), .open_o(opn));
	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [FRAME_BITS-1:0] got, input logic [FRAME_BITS-1:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic [5:0] cv(input int c);
		return 6'(c) ^ 6'h2a;
	endfunction
	function automatic logic [FRAME_BITS-1:0] st(input logic [3:0] g, input logic [CHANNELS-1:0] f);
		logic [FRAME_BITS-1:0] s;
		s = '0;
		s[FRAME_BITS-1 -: 8] = {g, 4'h0};
		for (int c = 0; c < CHANNELS; c++)
			s[12*c +: 12] = {cv(c), 5'h00, f[c]};
		return s;
	endfunction
	// msb first; serial out is read mid-high, well clear of the fall-driven update
	task automatic xfer(input logic [FRAME_BITS-1:0] d, input int n);
		for (int i = FRAME_BITS - 1; i >= FRAME_BITS - n; i--) begin
			serial_data_in <= d[i];
			cyc(4);
			sck <= 1'h1;
			cyc(2);
			@(negedge clk);
			rx[i] = serial_data_out;
			cyc(2);
			sck <= 1'h0;
		end
	endtask
	// a long hold keeps the result fifo from draining
	task automatic load(input int hold);
		cyc(4);
		load_strobe <= 1'h1;
		cyc(hold);
		fs = ful;
		load_strobe <= 1'h0;
		cyc(8);
	endtask
	task automatic frame(input logic [3:0] cmd, input int n, input int hold);
		logic [FRAME_BITS-1:0] d;
		d = '0;
		d[FRAME_BITS-1 -: 8] = {cmd, 4'h0};
		for (int c = 0; c < CHANNELS; c++)
			d[12*c +: 12] = {cv(c), 6'h3f};
		xfer(d, n);
		load(hold);
	endtask
	initial begin
		int i;
		cyc(3);
		rst <= 1'h0;
		cyc(6);
		load(4);
		chk(syn, 1'h0);
		frame(CMD_COR, FRAME_BITS, 4);
		load(4);
		chk(syn, 1'h0);
		frame(CMD_PHS, FRAME_BITS, 4);
		chk(rx, st(4'h0, '1));
		frame(CMD_CRD, FRAME_BITS, 4);
		chk(rx, st(4'h2, '1));
		chk({phase_shift_mode, correction_disable}, 2'h3);
		$display("test modes done");
		frame(CMD_PHS, 100, 4);
		chk({syn, phase_shift_mode}, 2'h3);
		flt <= 1'h1;
		frame(CMD_CRD, FRAME_BITS, 4);
		flt <= 1'h0;
		chk(rx, st(4'hb, '1));
		chk(correction_disable, 1'h0);
		$display("test sync done");
		msk <= 48'h8000_0000_0001;
		frame(CMD_TEST, FRAME_BITS, 3000);
		chk(rx, st(4'h2, '0));
		chk(fs, 1'h1);
		for (i = 0; i < 40000 && open_test_indicator !== 1'h1; i++)
			cyc(1);
		chk(open_test_indicator, 1'h1);
		if (open_test_indicator !== 1'h1)
			summarize();
		frame(4'h0, FRAME_BITS, 4);
		chk(rx, st(4'h2, '1));
		frame(4'h0, FRAME_BITS, 4);
		chk(rx, st(4'h6, ~msk));
		chk(open_test_indicator, 1'h0);
		frame(4'h0, FRAME_BITS, 4);
		chk(rx, st(4'h2, '1));
		$display("test self test done");
		summarize();
	end
endmodule // lpd_status_top_tb
